/* rtl/fsst_core.sv */
// fifo status flags, interrupt pins and self-test control
`timescale 1ns/100ps

// Functional notes
// - a zero threshold count keeps the watermark flag raised.
// - threshold count register resets to 0x80.
// - not-empty flag, status bit 1, set while a sample waits.
// - not-empty flag clears as soon as the fifo is empty.
// - overrun flag, status bit 3, sets when new data replaces unread.
// - in oldest-saved mode, overrun sets when no room for a sample.
// - overrun clears when the host reads fifo contents.
// - overrun clears while the fifo is disabled.
// - self-test force bit applies the stimulus; clearing removes it.
// - axis results beyond range saturate at full scale.
// - watermark flag, bit 2, set while count reaches the threshold.
// - each irq pin ORs its mapped flags, polarity bit selects low.
module fsst_core
	import fsst_pkg::*;
#(
	parameter int CNT_W = 10,
	parameter int DEPTH = 512,
	parameter int AXIS_IN_W = 16,
	parameter int AXIS_OUT_W = 12
)
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// fifo occupancy and events
	input wire logic [CNT_W-1:0] fifo_count,
	input wire logic sample_push,
	input wire logic fifo_rd,
	output logic [1:0] fifo_mode,
	// axis result
	input wire logic signed [AXIS_IN_W-1:0] axis_raw,
	output logic signed [AXIS_OUT_W-1:0] axis_out,
	// self test
	output logic self_test_force,
	// interrupt pins
	output logic irq_pin_one_o,
	output logic irq_pin_one_oe,
	output logic irq_pin_two_o,
	output logic irq_pin_two_oe
);
	// ****************************************
	// registers
	// ****************************************
	logic [7:0] wm_count_r;
	logic [7:0] fifo_ctrl_r;
	logic [7:0] route_one_r;
	logic [7:0] route_two_r;
	logic [7:0] self_test_r;
	logic overrun_r;
	logic [7:0] reg_rdata_r;
	logic [AXIS_OUT_W-1:0] axis_out_r;
	logic irq_one_r;
	logic irq_two_r;
	logic irq_one_oe_r;
	logic irq_two_oe_r;

	function automatic logic [7:0] fsst_pin(input logic [7:0] route,
		input logic [7:0] stat);
		logic hit;
		hit = |(route[6:0] & stat[6:0]);
		fsst_pin = {7'h00, hit ^ route[FSST_BIT_ROUTE_LOW]};
	endfunction : fsst_pin

	// ****************************************
	// decode and flags
	// ****************************************
	wire wr_wm = reg_wr && reg_addr == FSST_ADDR_WM_COUNT;
	wire wr_ctrl = reg_wr && reg_addr == FSST_ADDR_FIFO_CTRL;
	wire wr_one = reg_wr && reg_addr == FSST_ADDR_ROUTE_ONE;
	wire wr_two = reg_wr && reg_addr == FSST_ADDR_ROUTE_TWO;
	wire wr_st = reg_wr && reg_addr == FSST_ADDR_SELF_TEST;
	wire [1:0] mode = fifo_ctrl_r[1:0];
	wire fifo_off = mode == FSST_MODE_OFF;
	wire [CNT_W-1:0] threshold = CNT_W'({fifo_ctrl_r[FSST_BIT_COUNT_HIGH],
		wm_count_r});
	wire full = fifo_count >= CNT_W'(DEPTH);
	// zero threshold trivially satisfied
	wire watermark = fifo_count >= threshold;
	wire not_empty = fifo_count != '0;
	// replace-unread and no-room both land on a push into a full fifo
	wire overrun_set = sample_push && full && !fifo_off;
	// set beats read-clear; disable always clears
	wire overrun_nxt = fifo_off ? 1'b0 :
		(overrun_set ? 1'b1 : (fifo_rd ? 1'b0 : overrun_r));
	wire [7:0] status = {4'h0, overrun_r, watermark, not_empty, 1'b0};
	wire [7:0] pin_one = fsst_pin(route_one_r, status);
	wire [7:0] pin_two = fsst_pin(route_two_r, status);
	wire [AXIS_OUT_W-1:0] axis_clip;
	// full-scale limits, only the checks below read them
	localparam logic signed [AXIS_IN_W-1:0] AXIS_MAX =
		AXIS_IN_W'((1 <<< (AXIS_OUT_W-1)) - 1);
	localparam logic signed [AXIS_IN_W-1:0] AXIS_MIN = ~AXIS_MAX;
	wire [7:0] rd_mux =
		reg_addr == FSST_ADDR_STATUS ? status :
		reg_addr == FSST_ADDR_FIFO_CTRL ? fifo_ctrl_r :
		reg_addr == FSST_ADDR_WM_COUNT ? wm_count_r :
		reg_addr == FSST_ADDR_ROUTE_ONE ? route_one_r :
		reg_addr == FSST_ADDR_ROUTE_TWO ? route_two_r :
		reg_addr == FSST_ADDR_SELF_TEST ? self_test_r : 8'h00;

	fsst_saturate #(.IN_W(AXIS_IN_W), .OUT_W(AXIS_OUT_W)) u_sat
	(
		.raw(axis_raw),
		.clipped(axis_clip)
	);

	// ****************************************
	// clocked state
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			wm_count_r <= FSST_WM_COUNT_RST;
			fifo_ctrl_r <= FSST_ZERO_RST;
			route_one_r <= FSST_ZERO_RST;
			route_two_r <= FSST_ZERO_RST;
			self_test_r <= FSST_ZERO_RST;
			overrun_r <= 1'b0;
			reg_rdata_r <= 8'h00;
			axis_out_r <= '0;
			irq_one_r <= 1'b0;
			irq_two_r <= 1'b0;
			irq_one_oe_r <= 1'b0;
			irq_two_oe_r <= 1'b0;
		end
		else
		begin
			if (wr_wm)
				wm_count_r <= reg_wdata;
			if (wr_ctrl)
				fifo_ctrl_r <= reg_wdata;
			if (wr_one)
				route_one_r <= reg_wdata;
			if (wr_two)
				route_two_r <= reg_wdata;
			if (wr_st)
				self_test_r <= {7'h00, reg_wdata[FSST_BIT_SELF_TEST]};
			overrun_r <= overrun_nxt;
			if (reg_rd)
				reg_rdata_r <= rd_mux;
			axis_out_r <= axis_clip;
			irq_one_r <= pin_one[0];
			irq_two_r <= pin_two[0];
			// nothing mapped leaves the pin undriven
			irq_one_oe_r <= |route_one_r[6:0];
			irq_two_oe_r <= |route_two_r[6:0];
		end
	end

	assign reg_rdata = reg_rdata_r;
	assign fifo_mode = mode;
	assign axis_out = axis_out_r;
	assign self_test_force = self_test_r[FSST_BIT_SELF_TEST];
	assign irq_pin_one_o = irq_one_r;
	assign irq_pin_one_oe = irq_one_oe_r;
	assign irq_pin_two_o = irq_two_r;
	assign irq_pin_two_oe = irq_two_oe_r;

	// ****************************************
	// checks
	// ****************************************
	a_wm_zero_set: assert property (@(posedge clk) disable iff (sys_rst)
		threshold == '0 |-> status[FSST_BIT_WATERMARK])
		else $error("watermark low with zero threshold");
	a_wm_reset_val: assert property (@(posedge clk)
		$past(sys_rst) && !sys_rst |-> wm_count_r == 8'h80)
		else $error("threshold reset value wrong");
	a_ne_set: assert property (@(posedge clk) disable iff (sys_rst)
		fifo_count != '0 |-> status[FSST_BIT_NOT_EMPTY])
		else $error("not-empty missing");
	a_ne_clear: assert property (@(posedge clk) disable iff (sys_rst)
		fifo_count == '0 |-> !status[FSST_BIT_NOT_EMPTY])
		else $error("not-empty stuck");
	a_ovr_set: assert property (@(posedge clk) disable iff (sys_rst)
		sample_push && full && !fifo_off |=> status[FSST_BIT_OVERRUN])
		else $error("overrun not set");
	a_ovr_oldest: assert property (@(posedge clk) disable iff (sys_rst)
		mode == FSST_MODE_OLDEST && sample_push && full |=> overrun_r)
		else $error("oldest-mode overrun missed");
	a_ovr_rdclr: assert property (@(posedge clk) disable iff (sys_rst)
		fifo_rd && !overrun_set |=> !overrun_r)
		else $error("overrun survived read");
	a_ovr_off: assert property (@(posedge clk) disable iff (sys_rst)
		fifo_off |=> !overrun_r)
		else $error("overrun set while disabled");
	a_st_follow: assert property (@(posedge clk) disable iff (sys_rst)
		wr_st |=> self_test_force == $past(reg_wdata[FSST_BIT_SELF_TEST]))
		else $error("self-test force not applied");
	a_wm_level: assert property (@(posedge clk) disable iff (sys_rst)
		status[FSST_BIT_WATERMARK] == (fifo_count >= threshold))
		else $error("watermark level wrong");
	a_irq_pol: assert property (@(posedge clk) disable iff (sys_rst)
		##1 irq_pin_one_o == ($past(|(route_one_r[6:0] & status[6:0]))
		^ $past(route_one_r[FSST_BIT_ROUTE_LOW])))
		else $error("irq one level wrong");
	a_st_reset: assert property (@(posedge clk)
		$past(sys_rst) && !sys_rst |-> !self_test_force)
		else $error("self-test force set after reset");
	a_sat_clip: assert property (@(posedge clk) disable iff (sys_rst)
		$signed(axis_raw) > $signed(AXIS_IN_W'((1 <<< (AXIS_OUT_W-1)) - 1))
		|=> axis_out == {1'b0, {(AXIS_OUT_W-1){1'b1}}})
		else $error("axis wrapped instead of clipping");

	// ****************************************
	// register port, flag, irq pin, self-test and axis clip checks
	// ****************************************

	a_rd_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");

	a_rd_data: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd |=> reg_rdata == $past(rd_mux))
		else $error("read data not from addressed register");

	a_rd_unmapped: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr == 8'h3f |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");

	a_ovr_beats_rd: assert property (@(posedge clk) disable iff (sys_rst)
		overrun_set && fifo_rd |=> overrun_r)
		else $error("read clear beat overrun set");

	a_ovr_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!overrun_set && !fifo_rd && !fifo_off |=> $stable(overrun_r))
		else $error("overrun changed with no event");

	a_ovr_stream: assert property (@(posedge clk) disable iff (sys_rst)
		mode == FSST_MODE_STREAM && sample_push && full |=> overrun_r)
		else $error("stream-mode overrun missed");

	a_ovr_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		!overrun_r && !overrun_set |=> !overrun_r)
		else $error("overrun rose with no push into full fifo");

	a_wm_clear: assert property (@(posedge clk) disable iff (sys_rst)
		fifo_count < threshold |-> !status[FSST_BIT_WATERMARK])
		else $error("watermark set below threshold");

	a_wm_write: assert property (@(posedge clk) disable iff (sys_rst)
		wr_wm |=> wm_count_r == $past(reg_wdata))
		else $error("threshold count write lost");

	a_ctrl_write: assert property (@(posedge clk) disable iff (sys_rst)
		wr_ctrl |=> fifo_ctrl_r == $past(reg_wdata))
		else $error("fifo control write lost");

	a_route_write: assert property (@(posedge clk) disable iff (sys_rst)
		wr_one |=> route_one_r == $past(reg_wdata))
		else $error("route one write lost");

	a_irq_two_pol: assert property (@(posedge clk) disable iff (sys_rst)
		##1 irq_pin_two_o == ($past(|(route_two_r[6:0] & status[6:0]))
		^ $past(route_two_r[FSST_BIT_ROUTE_LOW])))
		else $error("irq two level wrong");

	a_oe_one: assert property (@(posedge clk) disable iff (sys_rst)
		##1 irq_pin_one_oe == $past(|route_one_r[6:0]))
		else $error("irq one drive enable wrong");

	a_oe_two: assert property (@(posedge clk) disable iff (sys_rst)
		##1 irq_pin_two_oe == $past(|route_two_r[6:0]))
		else $error("irq two drive enable wrong");

	a_st_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!wr_st |=> $stable(self_test_force))
		else $error("self-test force moved without a write");

	a_sat_low: assert property (@(posedge clk) disable iff (sys_rst)
		axis_raw < AXIS_MIN |=> axis_out == AXIS_MIN[AXIS_OUT_W-1:0])
		else $error("axis wrapped below negative full scale");

	a_sat_pass: assert property (@(posedge clk) disable iff (sys_rst)
		axis_raw <= AXIS_MAX && axis_raw >= AXIS_MIN
		|=> axis_out == $past(axis_raw[AXIS_OUT_W-1:0]))
		else $error("in-range axis value altered");
endmodule : fsst_core

/* rtl/fsst_pkg.sv */
// constants for the fifo status and self-test block
package fsst_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] FSST_ADDR_STATUS = 8'h0b;
	localparam logic [7:0] FSST_ADDR_FIFO_CTRL = 8'h28;
	localparam logic [7:0] FSST_ADDR_WM_COUNT = 8'h29;
	localparam logic [7:0] FSST_ADDR_ROUTE_ONE = 8'h2a;
	localparam logic [7:0] FSST_ADDR_ROUTE_TWO = 8'h2b;
	localparam logic [7:0] FSST_ADDR_SELF_TEST = 8'h2e;
	// ****************************************
	// field positions
	// ****************************************
	localparam int FSST_BIT_NOT_EMPTY = 1;
	localparam int FSST_BIT_WATERMARK = 2;
	localparam int FSST_BIT_OVERRUN = 3;
	localparam int FSST_BIT_COUNT_HIGH = 3;
	localparam int FSST_BIT_ROUTE_LOW = 7;
	localparam int FSST_BIT_SELF_TEST = 0;
	// ****************************************
	// reset values and modes
	// ****************************************
	localparam logic [7:0] FSST_WM_COUNT_RST = 8'h80;
	localparam logic [7:0] FSST_ZERO_RST = 8'h00;
	localparam logic [1:0] FSST_MODE_OFF = 2'h0;
	localparam logic [1:0] FSST_MODE_OLDEST = 2'h1;
	localparam logic [1:0] FSST_MODE_STREAM = 2'h2;
endpackage : fsst_pkg

/* rtl/fsst_saturate.sv */
// clips a wide axis result into the output word width
`timescale 1ns/100ps
module fsst_saturate
#(
	parameter int IN_W = 16,
	parameter int OUT_W = 12
)
(
	// wide result
	input wire logic signed [IN_W-1:0] raw,
	// clipped result
	output logic signed [OUT_W-1:0] clipped
);
	localparam logic signed [IN_W-1:0] MAX_V = IN_W'((1 <<< (OUT_W-1)) - 1);
	localparam logic signed [IN_W-1:0] MIN_V = -IN_W'(1 <<< (OUT_W-1));

	wire over = raw > MAX_V;
	wire under = raw < MIN_V;

	// clip to full scale, never wrap
	assign clipped = over ? MAX_V[OUT_W-1:0] :
		(under ? MIN_V[OUT_W-1:0] : raw[OUT_W-1:0]);
endmodule : fsst_saturate

/* tb/fsst_host.sv */
// host model that drives the core's register port
`timescale 1ns/100ps
module fsst_host
	import fsst_pkg::*;
(
	// clock and self-test view
	input wire logic clk,
	input wire logic self_test_force,
	// register port
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 18'h00000;
	// one strobe cycle; read data taken once the answering edge landed
	task acc(logic [7:0] a, logic [7:0] v, logic w, output logic [7:0] r);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		{reg_wr, reg_rd} <= {w, !w};
		@(posedge clk);
		{reg_wr, reg_rd} <= 2'b00;
		// released data is scrambled so nothing leans on a stale value
		reg_wdata <= ~v;
		#1;
		r = reg_rdata;
	endtask : acc
	// y axis assumed along gravity, so the forced output cannot clip
	task self_test(output logic on);
		logic [7:0] r;
		acc(FSST_ADDR_SELF_TEST, 8'h01, 1'b1, r);
		// one output-data period, shortened to a few clocks
		repeat (8) @(posedge clk);
		on = self_test_force;
		acc(FSST_ADDR_SELF_TEST, 8'h00, 1'b1, r);
	endtask : self_test
endmodule : fsst_host

/* tb/testbench.sv */
// self-checking bench for the fifo status and self-test core
`timescale 1ns/100ps
module testbench
	import fsst_pkg::*;
;
	logic clk = 1'b0, sys_rst = 1'b1, sample_push = 1'b0, fifo_rd = 1'b0;
	logic reg_wr, reg_rd, st, o1, e1, o2, e2;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d, e;
	logic [9:0] fifo_count = 10'h000, c;
	logic [8:0] thr;
	logic [1:0] fifo_mode;
	logic signed [15:0] axis_raw = 16'h0000;
	logic signed [11:0] axis_out;
	logic [15:0] corner [4] = '{16'h7fff, 16'h8000, 16'h07ff, 16'hf800};
	int err_total = 0, checks_done = 0;
	fsst_host i_fsst_host (.clk(clk), .self_test_force(st),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	fsst_core i_fsst_core (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .fifo_count(fifo_count), .fifo_rd(fifo_rd),
		.sample_push(sample_push), .fifo_mode(fifo_mode), .axis_raw(axis_raw),
		.axis_out(axis_out), .self_test_force(st), .irq_pin_one_o(o1),
		.irq_pin_one_oe(e1), .irq_pin_two_o(o2), .irq_pin_two_oe(e2));
	initial forever #10 clk = ~clk;
	function automatic logic signed [11:0] sat(logic signed [15:0] x);
		if (x > 16'sh07ff) return 12'h7ff;
		if (x < -16'sh0800) return 12'h800;
		return x[11:0];
	endfunction : sat
	task chk(logic [15:0] seen, logic [15:0] exp, string nm);
		checks_done++;
		err_total += (seen !== exp);
		if (seen !== exp)
			$display("Error %s expected %h seen %h", nm, exp, seen);
	endtask : chk
	task pulse(logic [1:0] v);
		@(posedge clk);
		{sample_push, fifo_rd} <= v;
		@(posedge clk);
		{sample_push, fifo_rd} <= 2'b00;
	endtask : pulse
	task end_sim;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim
	initial
	begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		void'($urandom(88));
		i_fsst_host.acc(FSST_ADDR_WM_COUNT, 8'h00, 1'b0, d);
		chk(d, FSST_WM_COUNT_RST, "wm_rst");
		i_fsst_host.acc(FSST_ADDR_SELF_TEST, 8'h00, 1'b0, d);
		chk({d, st}, 9'h000, "st_rst");
		i_fsst_host.acc(8'h3f, 8'h00, 1'b0, d);
		chk(d, 8'h00, "unmapped");
		// corners first: zero threshold, empty fifo, count at threshold
		for (int i = 0; i < 16; i++)
		begin
			thr = (i == 0) ? 9'h000 : 9'($urandom);
			c = (i == 1) ? 10'h000 : 10'($urandom % 512);
			if (i == 2) c = {1'b0, thr};
			axis_raw <= (i < 4) ? corner[i] : 16'($urandom);
			i_fsst_host.acc(FSST_ADDR_FIFO_CTRL, {4'h0, thr[8], 3'h2}, 1'b1, d);
			i_fsst_host.acc(FSST_ADDR_WM_COUNT, thr[7:0], 1'b1, d);
			fifo_count <= c;
			i_fsst_host.acc(FSST_ADDR_STATUS, 8'h00, 1'b0, d);
			e = {5'h00, c >= {1'b0, thr}, c != 10'h000, 1'b0};
			chk(d, e, "status");
			chk(axis_out, sat(axis_raw), "axis");
		end
		// overrun in both enabled modes; fifo read, then disable, clears it
		fifo_count <= 10'h200;
		for (int m = 1; m < 3; m++)
		begin
			i_fsst_host.acc(FSST_ADDR_FIFO_CTRL, 8'(m), 1'b1, d);
			pulse(2'b10);
			i_fsst_host.acc(FSST_ADDR_STATUS, 8'h00, 1'b0, d);
			chk(d[3], 1'b1, "ovr_set");
			pulse({1'b0, m == 1});
			if (m == 2) i_fsst_host.acc(FSST_ADDR_FIFO_CTRL, 8'h00, 1'b1, d);
			i_fsst_host.acc(FSST_ADDR_STATUS, 8'h00, 1'b0, d);
			chk({d[3], fifo_mode}, {1'b0, 2'(m % 2)}, "ovr_clr");
		end
		i_fsst_host.acc(FSST_ADDR_ROUTE_ONE, 8'h02, 1'b1, d);
		i_fsst_host.acc(FSST_ADDR_ROUTE_TWO, 8'h82, 1'b1, d);
		repeat (3) @(posedge clk);
		chk({o1, e1, o2, e2}, 4'b1101, "irq_pins");
		i_fsst_host.self_test(d[0]);
		chk({d[0], st}, 2'b10, "self_test");
		end_sim;
	end
endmodule : testbench
